//--- core/idt_cfg.svh
// constants for the instruction fetch and decode block
`ifndef IDT_CFG_SVH
`define IDT_CFG_SVH

`define IDT_OSC_PER_CYC 4
`define IDT_Q_LAST 2'h3
`define IDT_Q_STEP 2'h1
`define IDT_PC_W 20
`define IDT_PC_RESET 20'h00000
`define IDT_PC_ONE 20'h00001
`define IDT_PC_TWO 20'h00002

`define IDT_TOP 15:12
`define IDT_SUB 11:8
`define IDT_OPC 15:8
`define IDT_LO 7:0
`define IDT_D_BIT 9
`define IDT_A_BIT 8
`define IDT_B 11:9
`define IDT_PTR 5:4
`define IDT_KHI 3:0
`define IDT_N11 10:0
`define IDT_FF 11:0
`define IDT_S_CALL 8
`define IDT_S_RET 0
`define IDT_TBL_F 7:2
`define IDT_RET_F 7:1
`define IDT_M 1:0
`define IDT_EXT_HI 9:7

`define IDT_W2_MARK 4'hF
`define IDT_T_CTRL 4'h0
`define IDT_T_BYTE_LO 4'h1
`define IDT_T_BYTE_HI 4'h6
`define IDT_T_BYTE_SKIP 4'h6
`define IDT_T_BIT_LO 4'h7
`define IDT_T_BIT_HI 4'hB
`define IDT_T_BIT_SKIP 4'hA
`define IDT_T_MOVE2 4'hC
`define IDT_T_BRA 4'hD
`define IDT_T_MISC 4'hE
`define IDT_SUB_NONE 4'h0
`define IDT_SUB_CBR_HI 4'h7
`define IDT_SUB_EXT_HI 4'hB
`define IDT_SUB_CALL_HI 4'hD
`define IDT_SUB_PTR2 4'hE
`define IDT_SUB_GOTO 4'hF
`define IDT_TBL_RD 6'h02
`define IDT_TBL_WR 6'h03
`define IDT_RET_CODE 7'h09
`define IDT_IDX_LIM 8'h5F

`endif

//--- core/idt_core.sv
// instruction fetch, decode and cycle timing
`timescale 1ns/10ps
module idt_core (
    input wire logic clk,
    input wire logic rst,
    input wire logic extended_set_enable,
    input wire logic [15:0] prog_data,
    input wire logic cond_true,
    input wire logic [`IDT_PC_W-1:0] stack_top,
    output logic [`IDT_PC_W-1:0] prog_addr,
    output logic [1:0] q_phase,
    output idt_pkg::idt_out_t issue
);
    idt_pkg::idt_state_t s_q;
    idt_pkg::idt_state_t s_d;
    idt_pkg::idt_dec_t dn;
    logic cyc_en;
    logic redirect;
    logic [`IDT_PC_W-1:0] redir_pc;

    idt_field_decode u_dec (
        .word(prog_data),
        .ext_en(s_q.ext),
        .dec(dn)
    );

    function automatic logic [`IDT_PC_W-1:0] rel_target(
        input logic [`IDT_PC_W-1:0] pc,
        input logic signed [10:0] n
    );
        rel_target = `IDT_PC_W'(pc + `IDT_PC_W'(n) + `IDT_PC_ONE);
    endfunction

    function automatic idt_pkg::idt_out_t fill_out(input idt_pkg::idt_dec_t d);
        idt_pkg::idt_out_t o;
        o = '0;
        o.valid = 1'b1;
        o.kind = d.kind;
        o.op = d.op;
        o.dest_acc = d.dest_acc;
        o.acc_sel = d.acc_sel;
        o.indexed = d.indexed;
        o.file_addr = d.file_addr;
        o.bit_num = d.bit_num;
        o.lit = d.lit;
        o.ptr_sel = d.ptr_sel;
        o.fast = d.fast;
        o.tbl_mode = d.tbl_mode;
        o.ext_op = d.ext_op;
        o.cond = d.cond;
        o.pc_chg = d.pc_chg;
        return o;
    endfunction

    assign cyc_en = s_q.q == `IDT_Q_LAST;
    // test true or pc change adds a cycle
    assign redirect = s_q.pend_chg || (s_q.pend_cond && cond_true);
    assign redir_pc = s_q.pend_ret ? stack_top : s_q.pend_tgt;

    always_comb begin
        s_d = s_q;
        s_d.q = s_q.q + `IDT_Q_STEP;
        s_d.out.valid = 1'b0;
        if (cyc_en) begin
            s_d.out = '0;
            s_d.out.valid = 1'b1;
            s_d.out.kind = idt_pkg::K_NOP;
            s_d.pend_chg = 1'b0;
            s_d.pend_cond = 1'b0;
            s_d.pend_ret = 1'b0;
            if (redirect) begin
                s_d.pc = redir_pc;
                s_d.ph = idt_pkg::PH_RUN;
            end else if (s_q.ph == idt_pkg::PH_SECOND) begin
                s_d.ph = idt_pkg::PH_RUN;
                s_d.pc = s_q.pc + `IDT_PC_ONE;
                // second word must carry the mark
                if (prog_data[`IDT_TOP] == `IDT_W2_MARK) begin
                    s_d.out = fill_out(s_q.f1);
                    s_d.out.word2 = prog_data[`IDT_FF];
                    if (s_q.f1.kind == idt_pkg::K_PTR2) begin
                        s_d.out.lit = {s_q.f1.lit[`IDT_KHI], prog_data[`IDT_LO]};
                    end
                    if (s_q.f1.kind == idt_pkg::K_JUMP2) begin
                        // taken two-word branch adds a nop cycle
                        s_d.out.target = {prog_data[`IDT_FF], s_q.f1.lit[`IDT_LO]};
                        s_d.out.pc_chg = 1'b1;
                        s_d.pend_chg = 1'b1;
                        s_d.pend_tgt = {prog_data[`IDT_FF], s_q.f1.lit[`IDT_LO]};
                    end
                end
            end else begin
                s_d.pc = s_q.pc + `IDT_PC_ONE;
                if (dn.two_word) begin
                    // first word, wait for the second
                    s_d.ph = idt_pkg::PH_SECOND;
                    s_d.f1 = dn;
                end else if (!dn.lone2) begin
                    s_d.out = fill_out(dn);
                    s_d.pend_cond = dn.cond;
                    s_d.pend_chg = dn.pc_chg;
                    s_d.pend_ret = dn.is_ret;
                    s_d.pend_tgt = dn.is_rel ? rel_target(s_q.pc, dn.rel_n)
                        : `IDT_PC_W'(s_q.pc + `IDT_PC_TWO);
                    s_d.out.target = s_d.pend_tgt;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.pc <= `IDT_PC_RESET;
            // enable caught while reset is held
            s_q.ext <= extended_set_enable;
        end else begin
            s_q <= s_d;
        end
    end

    assign prog_addr = s_q.pc;
    assign q_phase = s_q.q;
    assign issue = s_q.out;

    AST_Q_PERIOD: assert property (@(posedge clk) disable iff (rst)
        cyc_en |=> !cyc_en [*3] ##1 cyc_en)
        else $error("instruction cycle is not four clocks");

    AST_BYTE_DEST: assert property (@(posedge clk) disable iff (rst)
        cyc_en && !redirect && s_q.ph == idt_pkg::PH_RUN && dn.kind == idt_pkg::K_BYTE
        |=> issue.valid && issue.kind == idt_pkg::K_BYTE
            && issue.dest_acc == !$past(prog_data[`IDT_D_BIT]))
        else $error("byte destination wrong");

    AST_BIT_FIELDS: assert property (@(posedge clk) disable iff (rst)
        cyc_en && !redirect && s_q.ph == idt_pkg::PH_RUN && dn.kind == idt_pkg::K_BIT
        |=> issue.bit_num == $past(prog_data[`IDT_B])
            && issue.file_addr[`IDT_LO] == $past(prog_data[`IDT_LO])
            && issue.acc_sel == $past(prog_data[`IDT_A_BIT]))
        else $error("bit op fields wrong");

    AST_LONE_SECOND: assert property (@(posedge clk) disable iff (rst)
        cyc_en && !redirect && s_q.ph == idt_pkg::PH_RUN
        && prog_data[`IDT_TOP] == `IDT_W2_MARK
        |=> issue.valid && issue.kind == idt_pkg::K_NOP)
        else $error("lone second word not a nop");

    AST_TWO_CYCLES: assert property (@(posedge clk) disable iff (rst)
        cyc_en && !redirect && s_q.ph == idt_pkg::PH_RUN && dn.two_word
        |=> s_q.ph == idt_pkg::PH_SECOND [*4] ##1 s_q.ph == idt_pkg::PH_RUN)
        else $error("double word not two cycles");

    AST_JUMP_THREE: assert property (@(posedge clk) disable iff (rst)
        cyc_en && !redirect && s_q.ph == idt_pkg::PH_SECOND
        && s_q.f1.kind == idt_pkg::K_JUMP2 && prog_data[`IDT_TOP] == `IDT_W2_MARK
        |=> issue.kind == idt_pkg::K_JUMP2 ##4 issue.valid && issue.kind == idt_pkg::K_NOP
            && prog_addr == $past(issue.target, 4))
        else $error("two-word branch timing wrong");

    AST_FLUSH_NOP: assert property (@(posedge clk) disable iff (rst)
        cyc_en && redirect
        |=> issue.valid && issue.kind == idt_pkg::K_NOP && prog_addr == $past(redir_pc))
        else $error("redirect slot not a nop");

    AST_SINGLE: assert property (@(posedge clk) disable iff (rst)
        cyc_en && !redirect && s_q.ph == idt_pkg::PH_RUN && !dn.two_word
        && !dn.cond && !dn.pc_chg
        |=> !s_q.pend_chg && !s_q.pend_cond ##3 !redirect)
        else $error("plain op stretched");

    AST_EXT_GATED: assert property (@(posedge clk) disable iff (rst)
        issue.valid && !s_q.ext |-> issue.kind != idt_pkg::K_EXT && !issue.indexed)
        else $error("extended op while disabled");

    AST_MARK: assert property (@(posedge clk) disable iff (rst)
        cyc_en && !redirect && s_q.ph == idt_pkg::PH_SECOND
        && prog_data[`IDT_TOP] != `IDT_W2_MARK
        |=> issue.kind == idt_pkg::K_NOP)
        else $error("unmarked second word executed");
endmodule // idt_core

//--- core/idt_field_decode.sv
// combinational field decoder for one program word
`timescale 1ns/10ps
module idt_field_decode (
    input wire logic [15:0] word,
    input wire logic ext_en,
    output idt_pkg::idt_dec_t dec
);
    always_comb begin
        dec = '0;
        dec.kind = idt_pkg::K_NOP;
        dec.op = word[`IDT_OPC];
        dec.file_addr = {4'h0, word[`IDT_LO]};
        dec.acc_sel = word[`IDT_A_BIT];
        dec.bit_num = word[`IDT_B];
        dec.dest_acc = !word[`IDT_D_BIT];
        dec.lit = {4'h0, word[`IDT_LO]};
        dec.ptr_sel = word[`IDT_PTR];
        dec.tbl_mode = word[`IDT_M];
        dec.rel_n = word[`IDT_N11];
        if (word[`IDT_TOP] == `IDT_T_CTRL) begin
            if (word[`IDT_SUB] == `IDT_SUB_NONE) begin
                dec.kind = idt_pkg::K_CTRL;
                if (word[`IDT_RET_F] == `IDT_RET_CODE) begin
                    dec.pc_chg = 1'b1;
                    dec.is_ret = 1'b1;
                    dec.fast = word[`IDT_S_RET];
                end else if (word[`IDT_TBL_F] != `IDT_TBL_RD && word[`IDT_TBL_F] != `IDT_TBL_WR) begin
                    dec.kind = idt_pkg::K_NOP;
                end
            end else begin
                dec.kind = idt_pkg::K_LIT;
            end
        end else if (word[`IDT_TOP] >= `IDT_T_BYTE_LO && word[`IDT_TOP] <= `IDT_T_BYTE_HI) begin
            dec.kind = idt_pkg::K_BYTE;
            dec.cond = word[`IDT_TOP] == `IDT_T_BYTE_SKIP;
        end else if (word[`IDT_TOP] >= `IDT_T_BIT_LO && word[`IDT_TOP] <= `IDT_T_BIT_HI) begin
            dec.kind = idt_pkg::K_BIT;
            dec.cond = word[`IDT_TOP] >= `IDT_T_BIT_SKIP;
        end else if (word[`IDT_TOP] == `IDT_T_MOVE2) begin
            dec.kind = idt_pkg::K_MOVE2;
            dec.two_word = 1'b1;
            dec.file_addr = word[`IDT_FF];
        end else if (word[`IDT_TOP] == `IDT_T_BRA) begin
            dec.kind = idt_pkg::K_CTRL;
            dec.pc_chg = 1'b1;
            dec.is_rel = 1'b1;
        end else if (word[`IDT_TOP] == `IDT_T_MISC) begin
            if (word[`IDT_SUB] <= `IDT_SUB_CBR_HI) begin
                dec.kind = idt_pkg::K_CTRL;
                dec.cond = 1'b1;
                dec.is_rel = 1'b1;
                dec.rel_n = 11'(signed'(word[`IDT_LO]));
            end else if (word[`IDT_SUB] <= `IDT_SUB_EXT_HI) begin
                if (ext_en) begin
                    dec.kind = idt_pkg::K_EXT;
                    dec.ext_op = word[`IDT_EXT_HI];
                end
            end else if (word[`IDT_SUB] <= `IDT_SUB_CALL_HI) begin
                dec.kind = idt_pkg::K_JUMP2;
                dec.two_word = 1'b1;
                dec.fast = word[`IDT_S_CALL];
            end else begin
                dec.kind = word[`IDT_SUB] == `IDT_SUB_PTR2 ? idt_pkg::K_PTR2 : idt_pkg::K_JUMP2;
                dec.two_word = 1'b1;
            end
        end else begin
            dec.lone2 = 1'b1;
        end
        dec.indexed = ext_en && (dec.kind == idt_pkg::K_BYTE || dec.kind == idt_pkg::K_BIT)
            && !word[`IDT_A_BIT] && word[`IDT_LO] <= `IDT_IDX_LIM;
    end
endmodule // idt_field_decode

//--- core/idt_pkg.sv
// types shared by the instruction fetch and decode block
`include "idt_cfg.svh"
package idt_pkg;

    // nine kinds need four bits; K_NOP is code 0 so a cleared word is a nop
    typedef enum logic [3:0] {
        K_NOP, K_BYTE, K_BIT, K_LIT, K_CTRL, K_EXT, K_MOVE2, K_PTR2, K_JUMP2
    } idt_kind_t;

    typedef enum logic {
        PH_RUN, PH_SECOND
    } idt_phase_t;

    typedef struct packed {
        idt_kind_t kind;
        logic [7:0] op;
        logic two_word;
        logic lone2;
        logic cond;
        logic pc_chg;
        logic is_ret;
        logic is_rel;
        logic signed [10:0] rel_n;
        logic dest_acc;
        logic acc_sel;
        logic indexed;
        logic [11:0] file_addr;
        logic [2:0] bit_num;
        logic [11:0] lit;
        logic [1:0] ptr_sel;
        logic fast;
        logic [1:0] tbl_mode;
        logic [2:0] ext_op;
    } idt_dec_t;

    typedef struct packed {
        logic valid;
        idt_kind_t kind;
        logic [7:0] op;
        logic dest_acc;
        logic acc_sel;
        logic indexed;
        logic [11:0] file_addr;
        logic [11:0] word2;
        logic [2:0] bit_num;
        logic [11:0] lit;
        logic [1:0] ptr_sel;
        logic [19:0] target;
        logic fast;
        logic [1:0] tbl_mode;
        logic [2:0] ext_op;
        logic cond;
        logic pc_chg;
    } idt_out_t;

    typedef struct packed {
        logic [1:0] q;
        idt_phase_t ph;
        logic [19:0] pc;
        idt_dec_t f1;
        logic pend_chg;
        logic pend_cond;
        logic pend_ret;
        logic [19:0] pend_tgt;
        logic ext;
        idt_out_t out;
    } idt_state_t;
endpackage

//--- verification/instruction_decode_timing_tb.sv
// self-checking bench for the instruction fetch and decode core
`timescale 1ns/10ps
module instruction_decode_timing_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic extended_set_enable = 1'b0;
    logic [15:0] prog_data = 16'h0000;
    logic cond_true = 1'b0;
    logic [19:0] stack_top = 20'h00000;
    logic [19:0] prog_addr;
    logic [1:0] q_phase;
    idt_pkg::idt_out_t issue;
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;
    int pa = 0;
    logic [7:0] f;
    logic d;

    idt_core idt_core_inst (
        .clk(clk),
        .rst(rst),
        .extended_set_enable(extended_set_enable),
        .prog_data(prog_data),
        .cond_true(cond_true),
        .stack_top(stack_top),
        .prog_addr(prog_addr),
        .q_phase(q_phase),
        .issue(issue)
    );

    always #25 clk = ~clk;

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // hang guard, far above the roughly 140 clocks the run needs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    task automatic do_reset(input logic en);
        @(negedge clk);
        rst = 1'b1;
        extended_set_enable = en;
        repeat (5) @(negedge clk);
        chk(prog_addr === 20'h00000 && q_phase === 2'h0 && issue.valid === 1'b0, "reset");
        rst = 1'b0;
        pa = 0;
    endtask

    // one instruction cycle; ea -1 next word, -2 unchecked, else redirect target
    task automatic cyc(input logic [15:0] w, input logic c, input int k, input int ea);
        int n;
        n = 0;
        while (q_phase !== 2'h3 && n < 4) begin
            @(negedge clk);
            n++;
        end
        chk(q_phase === 2'h3, "phase did not reach 3");
        prog_data = w;
        cond_true = c;
        @(negedge clk);
        chk(issue.valid === 1'b1 && q_phase === 2'h0, "valid or phase");
        if (k >= 0) chk(issue.kind === 4'(k), "kind");
        if (ea == -1) chk(prog_addr === 20'(pa + 1), "next address");
        if (ea >= 0) chk(prog_addr === 20'(ea), "redirect address");
        pa = (ea >= 0) ? ea : pa + 1;
        prog_data = ~w;
        cond_true = ~c;
    endtask

    initial begin
        void'($urandom(55630));
        do_reset(1'b0);
        for (int i = 0; i < 8; i++) begin
            f = 8'($urandom);
            d = 1'($urandom);
            cyc({4'h1 + 4'(i % 5), 2'b00, d, 1'b1, f}, 1'($urandom), idt_pkg::K_BYTE, -1);
            chk(issue.dest_acc === ~d, "destination select");
            chk(issue.file_addr[7:0] === f && issue.indexed === 1'b0, "file field");
        end
        cyc(16'h7A55, 1'b0, idt_pkg::K_BIT, -1);
        chk(issue.bit_num === 3'h5 && issue.file_addr[7:0] === 8'h55, "bit fields");
        cyc(16'h1010, 1'b0, idt_pkg::K_BYTE, -1);
        chk(issue.indexed === 1'b0, "indexed while disabled");
        cyc(16'hF123, 1'b0, idt_pkg::K_NOP, -1);
        cyc(16'hE880, 1'b0, idt_pkg::K_NOP, -1);
        cyc(16'hEE25, 1'b0, idt_pkg::K_NOP, -1);
        cyc(16'hF0AB, 1'b0, idt_pkg::K_PTR2, -1);
        chk(issue.lit === 12'h5AB && issue.ptr_sel === 2'h2, "pointer load");
        cyc(16'hEE25, 1'b0, idt_pkg::K_NOP, -1);
        cyc(16'h00AB, 1'b0, idt_pkg::K_NOP, -1);
        cyc(16'h0009, 1'b0, idt_pkg::K_CTRL, -1);
        chk(issue.tbl_mode === 2'h1, "table mode");
        cyc(16'h6610, 1'b0, idt_pkg::K_BYTE, -1);
        cyc(16'h1111, 1'b0, idt_pkg::K_BYTE, -1);
        cyc(16'h6610, 1'b0, idt_pkg::K_BYTE, -1);
        cyc(16'h1111, 1'b1, idt_pkg::K_NOP, pa + 1);
        cyc(16'hD005, 1'b0, -1, -1);
        cyc(16'h1111, 1'b0, idt_pkg::K_NOP, pa + 5);
        stack_top = 20'($urandom);
        cyc(16'h0013, 1'b0, idt_pkg::K_CTRL, -1);
        chk(issue.fast === 1'b1, "fast return");
        cyc(16'h1111, 1'b0, idt_pkg::K_NOP, int'(stack_top));
        cyc(16'hEF12, 1'b0, idt_pkg::K_NOP, -1);
        cyc(16'hF345, 1'b0, idt_pkg::K_JUMP2, -2);
        chk(issue.target === 20'h34512, "jump target");
        cyc(16'h1111, 1'b0, idt_pkg::K_NOP, 32'h34512);
        do_reset(1'b1);
        cyc(16'hE880, 1'b0, idt_pkg::K_EXT, -1);
        chk(issue.ext_op === 3'h1, "extended op");
        cyc(16'h105F, 1'b0, idt_pkg::K_BYTE, -1);
        chk(issue.indexed === 1'b1 && issue.dest_acc === 1'b1, "indexed at limit");
        cyc(16'h1060, 1'b0, idt_pkg::K_BYTE, -1);
        chk(issue.indexed === 1'b0, "above index limit");
        tally_and_finish();
    end
endmodule // instruction_decode_timing_tb
